/* File: src/aqmc_top.sv */
// Queue mode control: APB registers for both queues plus two trigger engines
// Assumes synchronous pins, APB4 master, stopMode level from the system
//
// Contract
// (RQ1) Queue 1 pause request when pause enabled
// (RQ2) Arm and single-scan mode in one write
// (RQ3) Arm bits read zero outside test mode
// (RQ4) Hardware clears queue 1 arm after scan
// (RQ5) Single-scan trigger counts only while armed
// (RQ6) Mode 0 off, mode 1 software single
// (RQ7) Modes 2,3 rising/falling edge single scan
// (RQ8) Modes 4..14 interval timer single scan
// (RQ9) Queue 1 mode 15 gated, 16 reserved
// (RQ10) Modes 17,18,19 software/edge continuous scan
// (RQ11) Modes 20..30 periodic timer continuous scan
// (RQ12) Queue 1 mode 31 gated continuous scan
// (RQ13) Stop mode forces queue 2 reset value
// (RQ14) Readable always, writes ignored in stop
// (RQ15) Queue 2 completion request when enabled
// (RQ16) Queue 2 pause request when enabled
// (RQ17) Queue 2 arm with mode in one write
// (RQ18) Hardware clears queue 2 arm after scan
// (RQ19) Queue 2 mode 1 software single scan
// (RQ20) Mode field sits in bits 12:8
// (RQ21) Queue 1 completion request when enabled
// (RQ22) Begin pointer ends queue 1; 64+ empties
// (RQ23) Resume bit picks queue 2 restart point
// (RQ24) Timer counts converter clocks, power of two
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "aqmc_regs.svh"
module aqmc_top
  import aqmc_pkg::*;
#(
  parameter int TIMER_BASE_EXP = `AQMC_TIMER_BASE_EXP
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        stopMode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        converterTick,
  input  wire logic        extTrig1,
  input  wire logic        extTrig2,
  input  wire logic        q1ConvDone,
  input  wire logic        q1CcwPause,
  input  wire logic        q1CcwLast,
  input  wire logic        q2ConvDone,
  input  wire logic        q2CcwPause,
  input  wire logic        q2CcwLast,
  output logic             q1Start,
  output logic             q2Start,
  output logic             q1Active,
  output logic             q2Active,
  output logic             q1GateOpen,
  output logic [4:0]       q1ModeSel,
  output logic [4:0]       q2ModeSel,
  output logic [6:0]       q2BeginPtr,
  output logic             q2NoEntries,
  output logic             q2Resume,
  output logic             q1DoneIrq,
  output logic             q1PauseIrq,
  output logic             q2DoneIrq,
  output logic             q2PauseIrq
);

  localparam logic [31:0] ADDR_Q1CTL = `AQMC_IDX_Q1CTL << 2;
  localparam logic [31:0] ADDR_Q2CTL = `AQMC_IDX_Q2CTL << 2;
  localparam logic [31:0] ADDR_AUX   = `AQMC_IDX_AUX << 2;
  localparam logic [15:0] Q1_RST     = `AQMC_Q1CTL_RST;
  localparam logic [15:0] Q2_RST     = `AQMC_Q2CTL_RST;

  aqmc_top_s r;
  aqmc_top_s next_r;

  aqmc_queue_if q1If ();
  aqmc_queue_if q2If ();

  ////////////////////////////////////////////////////////////////////////////
  // Trigger engines; queue 2 has no gated modes
  assign q1If.mode     = r.q1.mode;
  assign q1If.arm      = r.q1.arm;
  assign q1If.extTrig  = extTrig1;
  assign q1If.tick     = converterTick;
  assign q1If.scanDone = q1ConvDone & q1CcwLast;
  assign q2If.mode     = r.q2.mode;
  assign q2If.arm      = r.q2.arm;
  assign q2If.extTrig  = extTrig2;
  assign q2If.tick     = converterTick;
  assign q2If.scanDone = q2ConvDone & q2CcwLast;

  aqmc_queue #(
    .GATED_OK       (1'b1),
    .TIMER_BASE_EXP (TIMER_BASE_EXP)
  ) u_q1 (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .q       (q1If.seq)
  );

  aqmc_queue #(
    .GATED_OK       (1'b0),
    .TIMER_BASE_EXP (TIMER_BASE_EXP)
  ) u_q2 (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .q       (q2If.seq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field packing helpers
  function automatic logic [15:0] pack_q(input aqmc_qctl_s c, input logic showArm);
    logic [15:0] v;
    v = 16'h0000;
    v[`AQMC_BIT_DONE_EN]              = c.doneEn;
    v[`AQMC_BIT_PAUSE_EN]             = c.pauseEn;
    v[`AQMC_BIT_ARM]                  = c.arm & showArm;          // RQ3
    v[`AQMC_MODE_HI:`AQMC_MODE_LO]    = c.mode;                   // RQ20
    return v;
  endfunction

  function automatic aqmc_qctl_s unpack_q(input logic [15:0] v);
    aqmc_qctl_s c;
    c.doneEn  = v[`AQMC_BIT_DONE_EN];
    c.pauseEn = v[`AQMC_BIT_PAUSE_EN];
    c.arm     = v[`AQMC_BIT_ARM];
    c.mode    = v[`AQMC_MODE_HI:`AQMC_MODE_LO];                   // RQ20
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        setup;
    logic        commit;
    logic        hitQ1;
    logic        hitQ2;
    logic        hitAux;
    logic [31:0] rd;
    logic [15:0] wq;
    setup  = psel & penable & ~r.pready;
    commit = psel & penable & r.pready & pwrite & ~r.pslverr;
    hitQ1  = (paddr == ADDR_Q1CTL);
    hitQ2  = (paddr == ADDR_Q2CTL);
    hitAux = (paddr == ADDR_AUX);
    rd     = 32'h0000_0000;
    wq     = 16'h0000;
    next_r = r;
    next_r.pready = setup;
    next_r.pslverr = setup & ~(hitQ1 | hitQ2 | hitAux);
    if (setup) begin
      // Registers answer at any time, stop mode included
      if (hitQ1) begin
        rd[15:0] = pack_q(r.q1, r.testMode);                       // RQ14
      end else if (hitQ2) begin
        rd[15:0] = pack_q(r.q2, r.testMode);
        rd[`AQMC_BIT_RESUME]            = r.resume;
        rd[`AQMC_PTR_HI:`AQMC_PTR_LO]   = r.beginPtr;
      end else if (hitAux) begin
        rd[`AQMC_BIT_TEST]              = r.testMode;
        rd[`AQMC_BIT_ACT_LO]            = q1If.active;
        rd[`AQMC_BIT_ACT_LO + 1]        = q2If.active;
        rd[`AQMC_BIT_GATE_LO]           = q1If.gateOpen;
      end
      next_r.prdata = rd;
    end

    // Hardware clear first, so a same-cycle software write of one wins
    if (q1If.clearArm) begin
      next_r.q1.arm = 1'b0;                                        // RQ4
    end
    if (q2If.clearArm) begin
      next_r.q2.arm = 1'b0;                                        // RQ18
    end

    if (commit && !stopMode) begin                                 // RQ14
      if (hitQ1) begin
        wq = pack_q(r.q1, 1'b1);
        if (pstrb[1]) begin
          wq[15:8] = pwdata[15:8];
        end
        next_r.q1 = unpack_q(wq);                                  // RQ2
        if (!pstrb[1]) begin
          next_r.q1.arm = q1If.clearArm ? 1'b0 : r.q1.arm;
        end
      end else if (hitQ2) begin
        wq = pack_q(r.q2, 1'b1);
        wq[`AQMC_BIT_RESUME]          = r.resume;
        wq[`AQMC_PTR_HI:`AQMC_PTR_LO] = r.beginPtr;
        if (pstrb[1]) begin
          wq[15:8] = pwdata[15:8];
        end
        if (pstrb[0]) begin
          wq[7:0] = pwdata[7:0];
        end
        next_r.q2       = unpack_q(wq);                            // RQ17
        next_r.resume   = wq[`AQMC_BIT_RESUME];                    // RQ23
        next_r.beginPtr = wq[`AQMC_PTR_HI:`AQMC_PTR_LO];
        if (!pstrb[1]) begin
          next_r.q2.arm = q2If.clearArm ? 1'b0 : r.q2.arm;
        end
      end else if (hitAux && pstrb[0]) begin
        next_r.testMode = pwdata[`AQMC_BIT_TEST];
      end
    end

    // Stop mode holds both queue registers at reset
    if (stopMode) begin
      next_r.q1       = unpack_q(Q1_RST);
      next_r.q2       = unpack_q(Q2_RST);                          // RQ13
      next_r.resume   = Q2_RST[`AQMC_BIT_RESUME];
      next_r.beginPtr = Q2_RST[`AQMC_PTR_HI:`AQMC_PTR_LO];
    end

    // Requests are one-cycle pulses to the interrupt controller
    next_r.q1DoneIrq   = r.q1.doneEn & q1ConvDone & q1CcwLast;      // RQ21
    next_r.q1PauseIrq  = r.q1.pauseEn & q1ConvDone & q1CcwPause;    // RQ1
    next_r.q2DoneIrq   = r.q2.doneEn & q2ConvDone & q2CcwLast;      // RQ15
    next_r.q2PauseIrq  = r.q2.pauseEn & q2ConvDone & q2CcwPause;    // RQ16
    next_r.q2NoEntries = (next_r.beginPtr >= `AQMC_PTR_NONE);      // RQ22
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r             <= '0;
      r.q2          <= unpack_q(Q2_RST);
      r.resume      <= Q2_RST[`AQMC_BIT_RESUME];
      r.beginPtr    <= Q2_RST[`AQMC_PTR_HI:`AQMC_PTR_LO];
      r.q2NoEntries <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pready      = r.pready;
  assign pslverr     = r.pslverr;
  assign prdata      = r.prdata;
  assign q1Start     = q1If.start;
  assign q2Start     = q2If.start;
  assign q1Active    = q1If.active;
  assign q2Active    = q2If.active;
  assign q1GateOpen  = q1If.gateOpen;
  assign q1ModeSel   = r.q1.mode;
  assign q2ModeSel   = r.q2.mode;
  assign q2BeginPtr  = r.beginPtr;                                 // RQ22
  assign q2NoEntries = r.q2NoEntries;
  assign q2Resume    = r.resume;                                   // RQ23
  assign q1DoneIrq   = r.q1DoneIrq;
  assign q1PauseIrq  = r.q1PauseIrq;
  assign q2DoneIrq   = r.q2DoneIrq;
  assign q2PauseIrq  = r.q2PauseIrq;

endmodule

/* File: src/aqmc_regs.svh */
// Register offsets, field positions, reset values and timer constants
// Assumes word-aligned APB access with byte address equal to four times the index
`ifndef AQMC_REGS_SVH
`define AQMC_REGS_SVH

`define AQMC_IDX_Q1CTL      32'h00CA000C
`define AQMC_IDX_Q2CTL      32'h00CA000E
`define AQMC_IDX_AUX        32'h00CA0020

`define AQMC_BIT_DONE_EN    15
`define AQMC_BIT_PAUSE_EN   14
`define AQMC_BIT_ARM        13
`define AQMC_MODE_HI        12
`define AQMC_MODE_LO        8
`define AQMC_BIT_RESUME     7
`define AQMC_PTR_HI         6
`define AQMC_PTR_LO         0
`define AQMC_BIT_TEST       0
`define AQMC_BIT_ACT_LO     8
`define AQMC_BIT_GATE_LO    10

`define AQMC_Q1CTL_RST      16'h0000
`define AQMC_Q2CTL_RST      16'h007F
`define AQMC_PTR_NONE       7'h40

`define AQMC_TIMER_BASE_EXP 7
`define AQMC_TIMER_STEPS    10
`define AQMC_LOW_TIMER_FIRST 4'h4
`define AQMC_LOW_TIMER_LAST  4'hE
`define AQMC_LOW_SW          4'h1
`define AQMC_LOW_RISE        4'h2
`define AQMC_LOW_FALL        4'h3
`define AQMC_LOW_GATE        4'hF
`define AQMC_MODE_OFF        5'h00
`define AQMC_MODE_RSVD       5'h10

`endif

/* File: src/aqmc_pkg.sv */
// Types shared by the queue mode control block
// Assumes the register header supplies all numeric constants
package aqmc_pkg;

  typedef enum logic [1:0] {
    AQMC_IDLE = 2'b00,
    AQMC_RUN  = 2'b01,
    AQMC_END  = 2'b11
  } aqmc_state_e;

  typedef struct packed {
    aqmc_state_e state;
    logic        trigPrev;
    logic [31:0] ticks;
    logic        start;
    logic        clearArm;
    logic        active;
    logic        gateOpen;
  } aqmc_queue_s;

  typedef struct packed {
    logic       doneEn;
    logic       pauseEn;
    logic       arm;
    logic [4:0] mode;
  } aqmc_qctl_s;

  typedef struct packed {
    aqmc_qctl_s  q1;
    aqmc_qctl_s  q2;
    logic        resume;
    logic [6:0]  beginPtr;
    logic        testMode;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        q1DoneIrq;
    logic        q1PauseIrq;
    logic        q2DoneIrq;
    logic        q2PauseIrq;
    logic        q2NoEntries;
  } aqmc_top_s;

endpackage

/* File: src/aqmc_queue_if.sv */
// Link between the register side and one queue trigger engine
// Assumes both ends share clk and reset_n
`timescale 1ns/1ps
interface aqmc_queue_if;
  logic [4:0] mode;
  logic       arm;
  logic       extTrig;
  logic       tick;
  logic       scanDone;
  logic       start;
  logic       clearArm;
  logic       active;
  logic       gateOpen;

  modport ctrl (output mode, arm, extTrig, tick, scanDone,
                input  start, clearArm, active, gateOpen);
  modport seq  (input  mode, arm, extTrig, tick, scanDone,
                output start, clearArm, active, gateOpen);
endinterface

/* File: src/aqmc_queue.sv */
// Trigger engine of one queue: mode decode, edge, timer and gate triggers
// Assumes tick is a one-cycle converter clock pulse in the clk domain
`timescale 1ns/1ps
`include "aqmc_regs.svh"
module aqmc_queue
  import aqmc_pkg::*;
#(
  parameter bit GATED_OK       = 1'b1,
  parameter int TIMER_BASE_EXP = `AQMC_TIMER_BASE_EXP
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  aqmc_queue_if.seq q
);

  if (TIMER_BASE_EXP < 1 || TIMER_BASE_EXP + `AQMC_TIMER_STEPS > 30) begin : g_chk
    $error("aqmc_queue: timer exponent out of range");
  end

  aqmc_queue_s r;
  aqmc_queue_s next_r;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [3:0]  low;
    logic        single;
    logic        valid;
    logic        isTimer;
    logic [31:0] period;
    logic        timerEvt;
    logic        evt;
    low      = q.mode[3:0];
    single   = ~q.mode[4];
    valid    = (q.mode != `AQMC_MODE_OFF) && (q.mode != `AQMC_MODE_RSVD) &&
               !(low == `AQMC_LOW_GATE && !GATED_OK);                  // RQ6 RQ9
    isTimer  = (low >= `AQMC_LOW_TIMER_FIRST) && (low <= `AQMC_LOW_TIMER_LAST);
    period   = 32'h1 << (TIMER_BASE_EXP + int'(low - `AQMC_LOW_TIMER_FIRST)); // RQ8 RQ11
    timerEvt = 1'b0;
    evt      = 1'b0;
    next_r   = r;
    next_r.start    = 1'b0;
    next_r.clearArm = 1'b0;
    next_r.trigPrev = q.extTrig;
    if (!(valid && isTimer)) begin
      next_r.ticks = 32'h0;
    end else if (q.tick) begin
      if (r.ticks == period - 32'h1) begin
        timerEvt     = 1'b1;                                           // RQ24
        next_r.ticks = 32'h0;
      end else begin
        next_r.ticks = r.ticks + 32'h1;
      end
    end
    unique case (low)
      `AQMC_LOW_SW:   evt = single ? q.arm : 1'b1;                     // RQ6 RQ10 RQ19
      `AQMC_LOW_RISE: evt = q.extTrig & ~r.trigPrev;                   // RQ7 RQ10
      `AQMC_LOW_FALL: evt = ~q.extTrig & r.trigPrev;                   // RQ7 RQ10
      `AQMC_LOW_GATE: evt = q.extTrig;                                 // RQ9 RQ12
      default:        evt = isTimer & timerEvt;
    endcase
    // Single-scan triggers only count while armed
    evt = valid & evt & (~single | q.arm);                             // RQ5
    unique case (r.state)
      AQMC_IDLE: begin
        if (evt) begin
          next_r.start = 1'b1;
          next_r.state = AQMC_RUN;
        end
      end
      AQMC_RUN: begin
        if (!valid || (low == `AQMC_LOW_GATE && !q.extTrig)) begin
          next_r.state = AQMC_IDLE;
        end else if (q.scanDone) begin
          next_r.clearArm = single;                                    // RQ4 RQ18
          next_r.state    = single ? AQMC_END : AQMC_IDLE;
        end
      end
      // One spare cycle lets the arm clear land before a new trigger is judged
      AQMC_END: next_r.state = AQMC_IDLE;
      default:  next_r.state = AQMC_IDLE;
    endcase
    next_r.active   = (next_r.state == AQMC_RUN);
    next_r.gateOpen = valid && (low == `AQMC_LOW_GATE) && q.extTrig;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q.start    = r.start;
  assign q.clearArm = r.clearArm;
  assign q.active   = r.active;
  assign q.gateOpen = r.gateOpen;

endmodule

/* File: bench/aqmc_properties.sv */
// Port checker for the queue mode control block
// Assumes bind onto aqmc_top with ce held high
`timescale 1ns/1ps
module aqmc_properties (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       stopMode,
  input wire logic       q1ConvDone,
  input wire logic       q1CcwPause,
  input wire logic       q1CcwLast,
  input wire logic       q2ConvDone,
  input wire logic       q2CcwPause,
  input wire logic       q2CcwLast,
  input wire logic       q1Start,
  input wire logic       q1Active,
  input wire logic [4:0] q1ModeSel,
  input wire logic [4:0] q2ModeSel,
  input wire logic [6:0] q2BeginPtr,
  input wire logic       q1DoneIrq,
  input wire logic       q1PauseIrq,
  input wire logic       q2DoneIrq,
  input wire logic       q2PauseIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////
  q1_pause_irq_a: assert property (q1PauseIrq |-> $past(q1ConvDone & q1CcwPause))
    else $error("queue 1 pause request without cause");
  q1_done_irq_a: assert property (q1DoneIrq |-> $past(q1ConvDone & q1CcwLast))
    else $error("queue 1 done request without cause");
  q2_done_irq_a: assert property (q2DoneIrq |-> $past(q2ConvDone & q2CcwLast))
    else $error("queue 2 done request without cause");
  q2_pause_irq_a: assert property (q2PauseIrq |-> $past(q2ConvDone & q2CcwPause))
    else $error("queue 2 pause request without cause");
  start_pulse_a: assert property (q1Start |-> q1Active ##1 !q1Start)
    else $error("start pulse malformed");
  // Three cycles of margin cover the lag between field and engine
  q1_off_quiet_a: assert property ((q1ModeSel == 5'h00) [*3] |-> !q1Start)
    else $error("start while disabled");
  q1_rsvd_quiet_a: assert property ((q1ModeSel == 5'h10) [*3] |-> !q1Start)
    else $error("start in reserved mode");
  stop_reset_a: assert property (stopMode [*3] |-> q2BeginPtr == 7'h7F && q2ModeSel == 5'h00)
    else $error("stop mode left queue 2 control set");
  cover property (q1Start && q1ModeSel == 5'h1F);
  cover property (q2DoneIrq);
  cover property (q1PauseIrq);
endmodule

bind aqmc_top aqmc_properties i_props (
  .clk, .reset_n, .stopMode, .q1ConvDone, .q1CcwPause, .q1CcwLast, .q2ConvDone,
  .q2CcwPause, .q2CcwLast, .q1Start, .q1Active, .q1ModeSel, .q2ModeSel, .q2BeginPtr,
  .q1DoneIrq, .q1PauseIrq, .q2DoneIrq, .q2PauseIrq);

/* File: bench/adc_queue_mode_control_test.sv */
// Self-checking bench for the queue mode control block
// Assumes aqmc_top and the register header; ce and byte strobes held on
`timescale 1ns/1ps
`include "aqmc_regs.svh"
module adc_queue_mode_control_test;
  localparam int          TB_EXP = 1;
  localparam logic [31:0] A1     = `AQMC_IDX_Q1CTL * 4;
  localparam logic [31:0] A2     = `AQMC_IDX_Q2CTL * 4;
  localparam logic [31:0] AX     = `AQMC_IDX_AUX * 4;
  localparam logic [9:0]  TAB [10] = '{
    {5'h01, 1'h0, 3'h0, 1'h0},
    {5'h01, 1'h1, 3'h0, 1'h1},
    {5'h02, 1'h0, 3'h1, 1'h0},
    {5'h02, 1'h1, 3'h1, 1'h1},
    {5'h03, 1'h1, 3'h2, 1'h1},
    {5'h11, 1'h0, 3'h0, 1'h1},
    {5'h12, 1'h0, 3'h1, 1'h1},
    {5'h13, 1'h0, 3'h2, 1'h1},
    {5'h10, 1'h1, 3'h0, 1'h0},
    {5'h00, 1'h1, 3'h1, 1'h0}};
  logic                 clk = 1'h0;
  logic                 reset_n = 1'h0;
  logic                 stopMode = 1'h0;
  logic                 psel = 1'h0;
  logic                 penable = 1'h0;
  logic                 pwrite = 1'h0;
  logic                 tick = 1'h0;
  logic                 tickOn = 1'h0;
  logic [31:0]          paddr = '0;
  logic [31:0]          pwdata = '0;
  logic [1:0]           trig = '0;
  logic [1:0]           done = '0;
  logic [1:0]           pause = '0;
  logic [1:0]           last = '0;
  logic [31:0]          rd;
  logic                 err;
  int                   cyc = 0;
  int                   nMismatch = 0;
  int                   numChecks = 0;
  wire logic            pready, pslverr, q1GateOpen, q2NoEntries, q2Resume;
  wire logic [31:0]     prdata;
  wire logic [6:0]      q2BeginPtr;
  wire logic [1:0]      start, active, dIrq, pIrq;
  wire logic [1:0][4:0] modeSel;

  aqmc_top #(.TIMER_BASE_EXP(TB_EXP)) i_dut (
    .clk, .reset_n, .ce(1'h1), .stopMode, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .pready, .pslverr, .prdata, .converterTick(tick),
    .extTrig1(trig[0]), .extTrig2(trig[1]), .q1ConvDone(done[0]), .q1CcwPause(pause[0]),
    .q1CcwLast(last[0]), .q2ConvDone(done[1]), .q2CcwPause(pause[1]), .q2CcwLast(last[1]),
    .q1Start(start[0]), .q2Start(start[1]), .q1Active(active[0]), .q2Active(active[1]),
    .q1GateOpen, .q1ModeSel(modeSel[0]), .q2ModeSel(modeSel[1]), .q2BeginPtr,
    .q2NoEntries, .q2Resume, .q1DoneIrq(dIrq[0]), .q1PauseIrq(pIrq[0]),
    .q2DoneIrq(dIrq[1]), .q2PauseIrq(pIrq[1]));

  always #5 clk = ~clk;
  // Converter clock stand-in: one pulse every six system clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tick <= tickOn && (cyc % 6 == 0);
  end
  //////////////////////////////////////////////////
  function logic [31:0] qa(input int q);
    return q ? A2 : A1;
  endfunction
  function logic [31:0] ctl(input bit en, input bit arm, input logic [4:0] m, input int q);
    return {16'h0, en, en, arm, m, q ? 8'h7F : 8'h00};
  endfunction
  task chk(input bit ok, input string msg);
    numChecks++;
    if (!ok) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task testDone();
    if (nMismatch == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task apb(input bit wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      nMismatch++;
      testDone();
    end
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd === e, "read value");
  endtask
  task pulse(input int q, input bit l);
    done[q] <= 1'h1;
    pause[q] <= !l;
    last[q] <= l;
    @(posedge clk);
    done <= '0;
    pause <= '0;
    last <= '0;
    @(posedge clk);
  endtask
  // Kind: 0 none, 1 rising, 2 falling, 3 gate high, 4 timer ticks
  task scan(input int q, input logic [4:0] m, input bit arm, input int kind, input bit ex);
    int n;
    int t;
    bit en;
    en = 1'($urandom);
    n = 0;
    t = 0;
    trig[q] <= (kind == 2);
    apb(1'h1, qa(q), ctl(en, arm, m, q));
    tickOn <= (kind == 4);
    @(posedge clk);
    if (kind inside {[1:3]})
      trig[q] <= (kind != 2);
    while (start[q] !== 1'h1 && n < (ex ? 20000 : 30)) begin
      @(posedge clk);
      n++;
      t += tick;
    end
    tickOn <= 1'h0;
    chk(start[q] === ex, "start");
    if (ex && start[q] !== 1'h1)
      testDone();
    if (ex) begin
      chk(active[q] === 1'h1, "active");
      if (kind == 4)
        chk(t == (1 << (TB_EXP + m[3:0] - 4)), "timer period");
      if (kind == 3 && q == 0)
        chk(q1GateOpen === 1'h1, "gate");
      pulse(q, 1'h0);
      chk(pIrq[q] === en && dIrq[q] === 1'h0, "pause request");
      pulse(q, 1'h1);
      chk(dIrq[q] === en, "done request");
    end
    rdc(qa(q), ctl(en, arm & ~(ex & ~m[4]), m, q));
    trig[q] <= 1'h0;
    apb(1'h1, qa(q), ctl(1'h0, 1'h0, 5'h00, q));
  endtask
  //////////////////////////////////////////////////
  initial begin
    bit [15:0] v;
    void'($urandom(32'h98FD));
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    rdc(A1, 32'h0);
    rdc(A2, 32'h7F);
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 16'h0040 : (i == 1) ? 16'hFFBF : 16'($urandom);
      for (int q = 0; q < 2; q++) begin
        apb(1'h1, qa(q), {16'h0, v});
        rdc(qa(q), {16'h0, v[15:14], 1'h0, v[12:8], q ? v[7:0] : 8'h00});
        chk(modeSel[q] === v[12:8], "mode field");
      end
      chk(q2BeginPtr === v[6:0] && q2NoEntries === v[6] && q2Resume === v[7], "ptr");
    end
    // Mode 0 aborts any scan the random writes started
    apb(1'h1, A1, 32'h0);
    apb(1'h1, A2, 32'h7F);
    apb(1'h0, 32'h0328_0100, 32'h0);
    chk(err === 1'h1, "unmapped address");
    apb(1'h1, AX, 32'h1);
    rdc(AX, 32'h1);
    for (int q = 0; q < 2; q++)
      foreach (TAB[j])
        scan(q, TAB[j][9:5], TAB[j][4], TAB[j][3:1], TAB[j][0]);
    scan(0, 5'h0F, 1'h1, 3, 1'h1);
    scan(0, 5'h1F, 1'h0, 3, 1'h1);
    scan(1, 5'h0F, 1'h1, 3, 1'h0);
    scan(1, 5'h1F, 1'h0, 3, 1'h0);
    for (int k = 4; k < 15; k++) begin
      scan(0, 5'(k), 1'h1, 4, 1'h1);
      scan(1, 5'(k + 16), 1'h0, 4, 1'h1);
    end
    apb(1'h1, A2, 32'hC500);
    stopMode <= 1'h1;
    apb(1'h1, A1, 32'h0500);
    rdc(A1, 32'h0);
    rdc(A2, 32'h7F);
    stopMode <= 1'h0;
    apb(1'h1, A1, 32'h0500);
    rdc(A1, 32'h0500);
    testDone();
  end
endmodule
